// *** rtl/ptm_pkg.sv ***
package ptm_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFF_CTRL_A  = 8'h00;
  localparam logic [7:0] OFF_CTRL_B  = 8'h04;
  localparam logic [7:0] OFF_CNT_LO  = 8'h08;
  localparam logic [7:0] OFF_CNT_HI  = 8'h0C;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_PER_LO  = 8'h18;
  localparam logic [7:0] OFF_PER_HI  = 8'h1C;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // ==========================================================================
  // field positions
  localparam int POS_PAUSE  = 7;
  localparam int POS_CKSEL  = 4;
  localparam int POS_ON     = 3;
  localparam int POS_MODE   = 6;
  localparam int POS_PINF   = 4;
  localparam int POS_OLVL   = 3;
  localparam int POS_POL    = 2;
  localparam int POS_CLRSEL = 0;
  localparam int POS_AFLAG  = 0;
  localparam int POS_PFLAG  = 1;

  // ==========================================================================
  // reset values and constants
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [9:0] RST_VAL10  = 10'h000;
  localparam logic [9:0] CNT_MAX    = 10'h3FF;
  localparam logic [7:0] DIV16_LAST = 8'h0F;
  localparam logic [7:0] DIV64_LAST = 8'h3F;
  localparam logic [7:0] DIV4_LAST  = 8'h03;

  // ==========================================================================
  // encodings
  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'h0,
    PTM_MODE_UND = 2'h1,
    PTM_MODE_PWM = 2'h2,
    PTM_MODE_TMR = 2'h3
  } ptm_mode_e;

  typedef enum logic [2:0] {
    PTM_CK_SYS4  = 3'h0,
    PTM_CK_SYS   = 3'h1,
    PTM_CK_H16   = 3'h2,
    PTM_CK_H64   = 3'h3,
    PTM_CK_SUB0  = 3'h4,
    PTM_CK_SUB1  = 3'h5,
    PTM_CK_EXTR  = 3'h6,
    PTM_CK_EXTF  = 3'h7
  } ptm_cksel_e;

  typedef enum logic [2:0] {
    PTM_ST_OFF   = 3'b001,
    PTM_ST_RUN   = 3'b010,
    PTM_ST_PAUSE = 3'b100
  } ptm_state_e;

  typedef struct packed {
    logic [7:0] paddr;
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [31:0] pwdata;
  } ptm_apb_req_s;

endpackage : ptm_pkg

// *** rtl/ptm_timer.sv ***
// ============================================================================
// Notes on behaviour
// [R1] ten-bit up-counter from selected clock source
// [R2] comparators A and P on all bits
// [R3] counter cleared only by on-rise, overflow, match
// [R4] pause holds count, resume from held value
// [R5] three-bit field selects count clock source
// [R6] on-rise clears and starts; on-fall stops, holds
// [R7] on-rise returns pin to initial level
// [R8] two-bit mode field selects operating mode
// [R9] software turns timer off before mode change
// [R10] compare mode: A match drives pin per field
// [R11] pwm mode: field forces or selects waveform
// [R12] requested level equal initial gives no change
// [R13] software changes pin field only when off
// [R14] level bit sets initial or active level
// [R15] polarity bit inverts pin outside timer mode
// [R16] software writes zero to reserved bit
// [R17] clear source: A match, or P/overflow
// [R18] pwm and pulse modes ignore clear select
// [R19] unimplemented control bits read zero
// [R20] count readable, compare pairs read/write
// [R21] automatic clear raises interrupt request
// [R22] flag raising per clear source, A zero
// [R23] pwm period is P+1 counts, zero gives 1024
// [R24] increment once per active count edge
module ptm_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // internal clock enables
  input  wire logic        high_speed_clock,
  input  wire logic        sub_clock,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        external_count_input,
  output logic             waveform_output_pin,
  output logic             timer_irq
);

  // ==========================================================================
  // registers
  logic [7:0] timer_control_a;
  logic [7:0] timer_control_b;
  logic [9:0] compare_a_value;
  logic [9:0] period_compare_value;
  logic [9:0] count;
  logic       compare_a_flag;
  logic       period_match_flag;
  logic       pin_raw;
  logic       on_d;
  logic       ext_d;
  logic       hs_d;
  logic       sub_d;
  logic [7:0] pre4;
  logic [7:0] pre16;
  logic       pwm_phase;
  ptm_pkg::ptm_state_e state;
  ptm_pkg::ptm_state_e next_state;

  // ==========================================================================
  // field decode
  wire       pause_control        = timer_control_a[ptm_pkg::POS_PAUSE];
  wire [2:0] count_clock_select   = timer_control_a[ptm_pkg::POS_CKSEL +: 3];
  wire       timer_on_control     = timer_control_a[ptm_pkg::POS_ON];
  wire [1:0] mode_select          = timer_control_b[ptm_pkg::POS_MODE +: 2];
  wire [1:0] pin_function_select  = timer_control_b[ptm_pkg::POS_PINF +: 2];
  wire       output_level_control = timer_control_b[ptm_pkg::POS_OLVL];
  wire       output_polarity      = timer_control_b[ptm_pkg::POS_POL];
  wire       clear_source_select  = timer_control_b[ptm_pkg::POS_CLRSEL];

  wire is_pwm = (mode_select == ptm_pkg::PTM_MODE_PWM);
  wire is_tmr = (mode_select == ptm_pkg::PTM_MODE_TMR);
  wire is_cmp = (mode_select == ptm_pkg::PTM_MODE_CMP);
  wire is_pulse = is_pwm && (pin_function_select == 2'h3);

  // ==========================================================================
  // apb decode
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;
  wire on_rise = timer_on_control && !on_d;
  wire [7:0] next_ctrl_a = {pwdata[7:3], 3'h0};

  // ==========================================================================
  // count clock tick selection
  wire hs_rise  = high_speed_clock && !hs_d;
  wire sub_rise = sub_clock && !sub_d;
  wire ext_rise = external_count_input && !ext_d;
  wire ext_fall = !external_count_input && ext_d;
  wire tick_div4  = (pre4 == ptm_pkg::DIV4_LAST);
  wire tick_h16   = hs_rise && (pre16[3:0] == ptm_pkg::DIV16_LAST[3:0]);
  wire tick_h64   = hs_rise && (pre16[5:0] == ptm_pkg::DIV64_LAST[5:0]);
  logic tick;
  always_comb begin
    case (count_clock_select) // [R5]
      ptm_pkg::PTM_CK_SYS4: tick = tick_div4;
      ptm_pkg::PTM_CK_SYS:  tick = 1'b1;
      ptm_pkg::PTM_CK_H16:  tick = tick_h16;
      ptm_pkg::PTM_CK_H64:  tick = tick_h64;
      ptm_pkg::PTM_CK_SUB0: tick = sub_rise;
      ptm_pkg::PTM_CK_SUB1: tick = sub_rise;
      ptm_pkg::PTM_CK_EXTR: tick = ext_rise;
      default:              tick = ext_fall;
    endcase
  end

  // ==========================================================================
  // comparators and clear logic
  wire match_a = (count == compare_a_value); // [R2]
  wire match_p = (count == period_compare_value); // [R2]
  wire at_max  = (count == ptm_pkg::CNT_MAX);
  wire run_tick = (state == ptm_pkg::PTM_ST_RUN) && tick; // [R24]
  wire a_zero   = (compare_a_value == ptm_pkg::RST_VAL10);
  wire p_zero   = (period_compare_value == ptm_pkg::RST_VAL10);
  // pwm period from P, zero means full span; A sets duty
  wire pwm_clear = p_zero ? at_max : match_p; // [R18] [R23]
  wire cmp_clear = clear_source_select ? (match_a && !a_zero) || (a_zero && at_max)
                                       : (p_zero ? at_max : match_p); // [R17]
  wire ev_a  = run_tick && match_a && !a_zero; // [R22]
  wire ev_p  = run_tick && (is_pwm ? match_p : (!clear_source_select && match_p)); // [R22]
  wire do_clear = run_tick && !is_pulse && (is_pwm ? pwm_clear : cmp_clear); // [R3]
  wire wrap_clear = run_tick && at_max; // [R3]
  wire pulse_end = run_tick && is_pulse && match_a;

  // ==========================================================================
  // state machine
  always_comb begin
    case (state)
      ptm_pkg::PTM_ST_OFF:   next_state = timer_on_control ? ptm_pkg::PTM_ST_RUN
                                                           : ptm_pkg::PTM_ST_OFF; // [R6]
      ptm_pkg::PTM_ST_RUN:   next_state = !timer_on_control ? ptm_pkg::PTM_ST_OFF :
                                          pause_control ? ptm_pkg::PTM_ST_PAUSE
                                                        : ptm_pkg::PTM_ST_RUN; // [R4]
      ptm_pkg::PTM_ST_PAUSE: next_state = !timer_on_control ? ptm_pkg::PTM_ST_OFF :
                                          pause_control ? ptm_pkg::PTM_ST_PAUSE
                                                        : ptm_pkg::PTM_ST_RUN; // [R4]
      default:               next_state = ptm_pkg::PTM_ST_OFF;
    endcase
  end

  // ==========================================================================
  // counter
  logic [9:0] next_count;
  always_comb begin
    if (on_rise) begin
      next_count = ptm_pkg::RST_VAL10; // [R6]
    end else if (do_clear || wrap_clear) begin
      next_count = ptm_pkg::RST_VAL10; // [R3]
    end else if (run_tick && !(is_pulse && match_a)) begin
      next_count = count + 10'h001; // [R1] [R24]
    end else begin
      next_count = count; // [R4]
    end
  end

  // ==========================================================================
  // pin waveform
  wire req_lvl = pin_function_select[1] ? 1'b1 : 1'b0;
  logic next_pin;
  always_comb begin
    next_pin = pin_raw;
    if (on_rise && !is_tmr) begin
      next_pin = output_level_control; // [R7] [R14]
    end else if (is_cmp && ev_a) begin
      case (pin_function_select) // [R10]
        2'h0:    next_pin = pin_raw;
        2'h3:    next_pin = !pin_raw;
        default: next_pin = (req_lvl == output_level_control) ? pin_raw : req_lvl; // [R12]
      endcase
    end else if (is_pwm) begin
      case (pin_function_select) // [R11]
        2'h0:    next_pin = !output_level_control;
        2'h1:    next_pin = output_level_control;
        2'h2:    next_pin = pwm_phase ? output_level_control : !output_level_control;
        default: next_pin = (pulse_end || !timer_on_control) ? !output_level_control
                                                              : pin_raw;
      endcase
    end
  end
  // duty: active from period start until A match
  wire next_phase = (on_rise || do_clear || wrap_clear) ? !a_zero :
                    (ev_a ? 1'b0 : pwm_phase);

  // ==========================================================================
  // read mux
  logic [31:0] rmux;
  always_comb begin
    case (paddr)
      ptm_pkg::OFF_CTRL_A:  rmux = {24'h0, timer_control_a[7:3], 3'h0}; // [R19]
      ptm_pkg::OFF_CTRL_B:  rmux = {24'h0, timer_control_b};
      ptm_pkg::OFF_CNT_LO:  rmux = {24'h0, count[7:0]}; // [R20]
      ptm_pkg::OFF_CNT_HI:  rmux = {30'h0, count[9:8]}; // [R20]
      ptm_pkg::OFF_CMPA_LO: rmux = {24'h0, compare_a_value[7:0]};
      ptm_pkg::OFF_CMPA_HI: rmux = {30'h0, compare_a_value[9:8]};
      ptm_pkg::OFF_PER_LO:  rmux = {24'h0, period_compare_value[7:0]};
      ptm_pkg::OFF_PER_HI:  rmux = {30'h0, period_compare_value[9:8]};
      ptm_pkg::OFF_STATUS:  rmux = {30'h0, period_match_flag, compare_a_flag};
      default:              rmux = 32'h0000_0000;
    endcase
  end
  wire known = (paddr <= ptm_pkg::OFF_STATUS) && (paddr[1:0] == 2'h0);
  wire clr_flags = apb_wr && (paddr == ptm_pkg::OFF_STATUS);

  // ==========================================================================
  // sequential
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_control_a      <= ptm_pkg::RST_CTRL_A;
      timer_control_b      <= ptm_pkg::RST_CTRL_B;
      compare_a_value      <= ptm_pkg::RST_VAL10;
      period_compare_value <= ptm_pkg::RST_VAL10;
      count                <= ptm_pkg::RST_VAL10;
      state                <= ptm_pkg::PTM_ST_OFF;
      compare_a_flag       <= 1'b0;
      period_match_flag    <= 1'b0;
      pin_raw              <= 1'b0;
      pwm_phase            <= 1'b0;
      on_d                 <= 1'b0;
      ext_d                <= 1'b0;
      hs_d                 <= 1'b0;
      sub_d                <= 1'b0;
      pre4                 <= 8'h00;
      pre16                <= 8'h00;
      prdata               <= 32'h0000_0000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
      waveform_output_pin  <= 1'b0;
      timer_irq            <= 1'b0;
    end else begin
      on_d   <= timer_on_control;
      ext_d  <= external_count_input;
      hs_d   <= high_speed_clock;
      sub_d  <= sub_clock;
      pre4   <= tick_div4 ? 8'h00 : pre4 + 8'h01;
      pre16  <= hs_rise ? ((pre16 == ptm_pkg::DIV64_LAST) ? 8'h00 : pre16 + 8'h01) : pre16;
      state  <= next_state;
      count  <= next_count;
      pin_raw <= next_pin;
      pwm_phase <= next_phase;
      // set wins over software clear
      compare_a_flag    <= ev_a || (compare_a_flag && !(clr_flags && pwdata[0])); // [R22]
      period_match_flag <= ev_p || (period_match_flag && !(clr_flags && pwdata[1])); // [R22]
      timer_irq <= ev_a || ev_p || (timer_irq && !clr_flags); // [R21]
      waveform_output_pin <= is_tmr ? 1'b0 : (next_pin ^ output_polarity); // [R15] [R8]
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !known;
      prdata  <= (psel && !penable && !pwrite) ? rmux : prdata;
      if (pulse_end) begin
        timer_control_a[ptm_pkg::POS_ON] <= 1'b0;
      end
      if (is_pulse && !timer_on_control && ext_rise) begin
        timer_control_a[ptm_pkg::POS_ON] <= 1'b1;
      end
      if (apb_wr && pready) begin
        case (paddr)
          ptm_pkg::OFF_CTRL_A:  timer_control_a <= next_ctrl_a; // [R19]
          ptm_pkg::OFF_CTRL_B:  timer_control_b <= pwdata[7:0]; // [R8] [R16]
          ptm_pkg::OFF_CMPA_LO: compare_a_value[7:0] <= pwdata[7:0]; // [R20]
          ptm_pkg::OFF_CMPA_HI: compare_a_value[9:8] <= pwdata[1:0];
          ptm_pkg::OFF_PER_LO:  period_compare_value[7:0] <= pwdata[7:0];
          ptm_pkg::OFF_PER_HI:  period_compare_value[9:8] <= pwdata[1:0];
          default:              timer_control_a <= timer_control_a;
        endcase
      end
    end
  end

  // ==========================================================================
  // assertions
  a_on_rise_clear: assert property (@(posedge clk) disable iff (!rstn)
    on_rise |=> (count == 10'h000)) // [R6]
    else $error("count not cleared on switch on");
  a_pause_hold: assert property (@(posedge clk) disable iff (!rstn)
    (state == ptm_pkg::PTM_ST_PAUSE) && !on_rise |=> $stable(count)) // [R4]
    else $error("count moved while paused");
  a_off_hold: assert property (@(posedge clk) disable iff (!rstn)
    (state == ptm_pkg::PTM_ST_OFF) && !on_rise |=> $stable(count)) // [R6]
    else $error("count moved while off");
  a_count_step: assert property (@(posedge clk) disable iff (!rstn)
    run_tick && !do_clear && !wrap_clear && !on_rise && !is_pulse
      |=> count == $past(count) + 10'h001) // [R24]
    else $error("count did not step");
  a_clear_match: assert property (@(posedge clk) disable iff (!rstn)
    do_clear && !on_rise |=> count == 10'h000) // [R17]
    else $error("count not cleared on match");
  a_aflag_set: assert property (@(posedge clk) disable iff (!rstn)
    ev_a |=> compare_a_flag) // [R22]
    else $error("A flag not raised");
  a_no_pflag: assert property (@(posedge clk) disable iff (!rstn)
    is_cmp && clear_source_select && !period_match_flag && !clr_flags
      |=> !period_match_flag) // [R22]
    else $error("P flag raised with A clear");
  a_init_level: assert property (@(posedge clk) disable iff (!rstn)
    on_rise && !is_tmr |=> pin_raw == $past(output_level_control)) // [R7]
    else $error("pin not at initial level");
  a_polarity: assert property (@(posedge clk) disable iff (!rstn)
    !is_tmr |=> waveform_output_pin == ($past(next_pin) ^ $past(output_polarity))) // [R15]
    else $error("pin polarity wrong");
  a_ctrl_low_zero: assert property (@(posedge clk) disable iff (!rstn)
    timer_control_a[2:0] == 3'h0) // [R19]
    else $error("unimplemented bits set");

endmodule : ptm_timer

// *** bench/ptm_ext_drv.sv ***
// ============================================================================
// far-side model: count input pin and the two internal clock sources
module ptm_ext_drv (
  // clock
  input  wire logic clk,
  // toward the timer
  output logic      ext_in,
  output logic      hs_clk,
  output logic      sub_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] div;

  initial begin
    ext_in  = 1'b0;
    hs_clk  = 1'b0;
    sub_clk = 1'b0;
    div     = 3'h0;
  end

  always @(posedge clk) begin
    div     <= div + 3'h1;
    hs_clk  <= ~hs_clk;
    sub_clk <= div[2];
  end

  // both levels held three clocks so each edge is seen once
  task automatic pulses(input int n);
    repeat (n) begin
      ext_in <= 1'b1;
      repeat (3) @(posedge clk);
      ext_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : pulses
endmodule : ptm_ext_drv

// *** bench/tb_top.sv ***
// ============================================================================
// self-checking bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rstn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_in;
  logic        hs_clk;
  logic        sub_clk;
  logic        pin;
  logic        irq;
  logic        slv;
  logic [31:0] q;
  logic [31:0] rnd;
  logic [7:0]  m[0:8];
  int          err_count;
  int          checks;

  ptm_timer ptm_timer_i (.clk(clk), .rstn(rstn), .high_speed_clock(hs_clk), .sub_clock(sub_clk),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_count_input(ext_in),
    .waveform_output_pin(pin), .timer_irq(irq));

  ptm_ext_drv ptm_ext_drv_i (.clk(clk), .ext_in(ext_in), .hs_clk(hs_clk), .sub_clk(sub_clk));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) err_count++;
    q   = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // model keeps what each writable register should hold
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] msk;
    msk = (a == 8'h00) ? 8'hF8 : (a == 8'h14 || a == 8'h1C) ? 8'h03 :
          (a == 8'h10 || a == 8'h18 || a == 8'h04) ? 8'hFF : 8'h00;
    apb(1'b1, a, {24'h0, d});
    if (msk !== 8'h00) m[a[5:2]] = d & msk;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic results;
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 40000);
    err_count++;
    results();
  end

  // ==========================================================================
  // scenarios
  initial begin
    logic [3:0] i;
    logic       e;
    logic [2:0] ck;
    int         c;
    int         nom;
    rstn = 1'b0; paddr = 8'h0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; pwdata = 32'h0;
    err_count = 0;
    checks = 0;
    rnd = 32'h2b435853;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 9; k++) m[k] = 8'h00;
    for (int k = 0; k < 8; k++) rd(8'(k * 4), 32'h0);
    wr(8'h00, 8'h17);
    rd(8'h00, 32'h10);
    wr(8'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(8'h10 + 8'(k * 4), rnd[7:0]);
      rd(8'h10 + 8'(k * 4), {24'h0, m[4 + k]});
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({q, 31'h0, slv}, {32'h0, 32'h1});
    // timer/counter mode, external edges, off/on and pause
    wr(8'h04, 8'hC0);
    wr(8'h18, 8'h00);
    wr(8'h1C, 8'h00);
    wr(8'h00, 8'h68);
    ptm_ext_drv_i.pulses(5);
    rd(8'h08, 32'd5);
    rd(8'h0C, 32'h0);
    chk({31'h0, pin}, 32'h0);
    wr(8'h00, 8'h60);
    ptm_ext_drv_i.pulses(2);
    rd(8'h08, 32'd5);
    wr(8'h00, 8'h78);
    rd(8'h08, 32'd0);
    ptm_ext_drv_i.pulses(4);
    rd(8'h08, 32'd4);
    wr(8'h00, 8'hF8);
    ptm_ext_drv_i.pulses(3);
    rd(8'h08, 32'd4);
    wr(8'h00, 8'h78);
    ptm_ext_drv_i.pulses(2);
    wr(8'h08, 8'hFF);
    rd(8'h08, 32'd6);
    // compare mode, period match clears the counter
    wr(8'h00, 8'h60);
    wr(8'h04, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h02);
    wr(8'h18, 8'h05);
    wr(8'h20, 8'h03);
    wr(8'h00, 8'h68);
    ptm_ext_drv_i.pulses(7);
    rd(8'h08, 32'd1);
    rd(8'h20, 32'h2);
    // compare A match action over every pin function, level and polarity
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h00);
    for (int k = 0; k < 16; k++) begin
      i = 4'(k);
      wr(8'h00, 8'h60);
      wr(8'h04, {2'b00, i[1:0], i[3], i[2], 2'b01});
      wr(8'h20, 8'h03);
      wr(8'h00, 8'h68);
      @(negedge clk);
      chk({31'h0, pin}, {31'h0, i[3] ^ i[2]});
      @(posedge clk);
      ptm_ext_drv_i.pulses(4);
      e = (i[1:0] == 2'b00) ? i[3] : (i[1:0] == 2'b11) ? ~i[3] : i[1];
      chk({31'h0, pin}, {31'h0, e ^ i[2]});
      chk({31'h0, irq}, 32'h1);
      rd(8'h08, 32'd0);
    end
    // pwm mode forced levels ignore the clear select
    for (int k = 0; k < 8; k++) begin
      i = 4'(k);
      wr(8'h00, 8'h60);
      wr(8'h04, {3'b100, i[0], i[1], i[2], 1'b0, i[0]});
      wr(8'h00, 8'h68);
      ptm_ext_drv_i.pulses(4);
      chk({31'h0, pin}, {31'h0, ~(i[0] ^ i[1]) ^ i[2]});
    end
    // internal count clocks: count over a fixed window, then pause and read
    wr(8'h04, 8'hC0);
    wr(8'h18, 8'h00);
    wr(8'h1C, 8'h00);
    for (int k = 0; k < 5; k++) begin
      ck  = (k == 0) ? 3'h0 : (k == 1) ? 3'h1 : (k == 2) ? 3'h2 : (k == 3) ? 3'h3 : 3'h4;
      nom = (k == 0) ? 64 : (k == 1) ? 256 : (k == 2) ? 8 : (k == 3) ? 2 : 32;
      wr(8'h00, 8'h00);
      wr(8'h00, {1'b0, ck, 1'b1, 3'h0});
      repeat (256) @(posedge clk);
      wr(8'h00, {1'b1, ck, 1'b1, 3'h0});
      apb(1'b0, 8'h08, 32'h0);
      c = int'(q[7:0]);
      apb(1'b0, 8'h0C, 32'h0);
      c = c + 256 * int'(q[1:0]);
      chk({31'h0, (c >= nom - 4) && (c <= nom + 6)}, 32'h1);
    end
    // reset in mid-run returns both control registers and the count to their reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h00, 8'h00);
    results();
  end
endmodule : tb_top
